// ==== include/srso_pkg.sv ====
// shared constants and types of the system reset, status and options block
package srso_pkg;

    // register word offsets (byte addresses)
    localparam logic [3:0] SRSO_OFF_STATUS = 4'h0;
    localparam logic [3:0] SRSO_OFF_DBGRST = 4'h4;
    localparam logic [3:0] SRSO_OFF_OPTS   = 4'h8;
    localparam logic [3:0] SRSO_OFF_CLKO   = 4'hc;

    // reset_cause_status bit positions
    localparam int SRSO_ST_POR  = 7;
    localparam int SRSO_ST_PIN  = 6;
    localparam int SRSO_ST_WDOG = 5;
    localparam int SRSO_ST_ILLEGAL_OPCODE_FLAG = 4;
    localparam int SRSO_ST_CLKG = 2;
    localparam int SRSO_ST_LVD  = 1;
    localparam logic [7:0] SRSO_ST_RST = 8'h82;

    // debug_forced_reset bit
    localparam int SRSO_DBG_FORCE = 0;

    // system_options_once bit positions and reset values
    localparam int SRSO_OPT_WDEN  = 7;
    localparam int SRSO_OPT_WDLNG = 6;
    localparam int SRSO_OPT_STOP  = 5;
    localparam logic SRSO_OPT_WDEN_RST  = 1'b1;
    localparam logic SRSO_OPT_WDLNG_RST = 1'b1;
    localparam logic SRSO_OPT_STOP_RST  = 1'b0;

    // clock_output_control fields
    localparam int SRSO_CLK_EN  = 4;
    localparam int SRSO_CLK_DLO = 0;
    localparam int SRSO_CLK_DW  = 3;

    // watchdog periods in bus clocks and internal reset stretch
    localparam int SRSO_WDOG_SHORT = 8192;
    localparam int SRSO_WDOG_LONG  = 262144;
    localparam int SRSO_WDOG_W     = 18;
    localparam int SRSO_HOLD_CYC   = 4;

    typedef enum logic [1:0] {
        SRSO_RUN  = 2'b01,
        SRSO_HOLD = 2'b10
    } srso_state_e;

    // reset sources seen by the block, synchronous to clk_sys
    typedef struct packed {
        logic pin_low;     // external reset pin held low
        logic clkgen_req;  // clock generator asks for reset
        logic unimpl_op;   // unimplemented opcode fetched
        logic stop_exec;   // stop instruction executed
        logic background_instruction_exec;   // background instruction executed
        logic lv_trip;     // supply below trip level
    } srso_src_s;

    typedef struct packed {
        srso_state_e             st;
        logic [2:0]              hold_cnt;
        logic [7:0]              status;
        logic                    wd_en;
        logic                    wd_long;
        logic                    stop_ok;
        logic                    locked;
        logic                    ck_en;
        logic [2:0]              ck_div;
        logic [2:0]              div_cnt;
        logic                    ck_out;
        logic [SRSO_WDOG_W-1:0]  wd_cnt;
        logic                    ph_val;
        logic                    ph_wr;
        logic [3:0]              ph_addr;
        logic [31:0]             rdata;
    } srso_regs_s;

endpackage

// ==== design/srso_top.sv ====
// system reset status, write-once options and divided clock output
// Functional notes
// - status flags read-only; bits 3,0 zero
// - debug forced reset leaves all flags clear
// - status write restarts watchdog, flags unchanged
// - power-on sets power-on and low-voltage flags
// - low-voltage reset keeps power-on, sets low-voltage
// - other resets: flag per active source
// - low reset pin marks pin cause
// - watchdog expiry marks cause; disabled means none
// - illegal opcode, disallowed stop or background
// - clock generator request marks its cause
// - low-voltage reset needs both enables and trip
// - forced-reset register reads zero, bus-write ignored
// - debug write of one forces full reset
// - options readable, first write only, bits 4-0 zero
// - watchdog enable option resets to one
// - period option: 2^13 short, 2^18 long
// - stop option zero: stop becomes illegal opcode
// - clock output enable drives divided clock on pin
// - output frequency is bus clock over twice select
// - zero select with enable drives pin low
// - enable forces pin to output direction
`timescale 1ns/1ps
`default_nettype none
module srso_top
    import srso_pkg::*;
#(
    parameter int WDOG_SHORT = SRSO_WDOG_SHORT,
    parameter int WDOG_LONG  = SRSO_WDOG_LONG
) (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire srso_src_s   rst_src,
    input  wire logic        bdm_allow,
    input  wire logic        lv_reset_en,
    input  wire logic        lv_stop_en,
    input  wire logic        dbg_wr,
    input  wire logic [7:0]  dbg_wdata,
    output logic             sys_reset,
    output logic             stop_enter,
    output logic             wdog_en_o,
    input  wire logic        port_out,
    input  wire logic        port_dir,
    output logic             pin_o,
    output logic             pin_oe
);

    srso_regs_s r_r;
    srso_regs_s r_nxt;

    logic                   addr_ph;
    logic                   wr_ph;
    logic                   illegal_op;
    logic                   lv_reset;
    logic                   wd_expire;
    logic                   force_rst;
    logic                   any_rst;
    logic [SRSO_WDOG_W-1:0] wd_limit;
    logic [7:0]             opts_rd;
    logic [7:0]             clko_rd;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = r_r.rdata;
    assign addr_ph   = hsel & htrans[1] & hready;
    // writes during the internal reset stretch are dropped: the cpu is held
    assign wr_ph     = r_r.ph_val & r_r.ph_wr & (r_r.st == SRSO_RUN);

    assign illegal_op = rst_src.unimpl_op
                      | (rst_src.stop_exec & ~r_r.stop_ok)
                      | (rst_src.background_instruction_exec & ~bdm_allow);
    assign stop_enter = (r_r.st == SRSO_RUN) & rst_src.stop_exec & r_r.stop_ok;
    assign lv_reset   = lv_reset_en & lv_stop_en & rst_src.lv_trip;
    assign wd_limit   = r_r.wd_long ? SRSO_WDOG_W'(WDOG_LONG - 1)
                                    : SRSO_WDOG_W'(WDOG_SHORT - 1);
    // >= so a count left above a newly shortened period still expires
    assign wd_expire  = r_r.wd_en & (r_r.wd_cnt >= wd_limit);
    assign force_rst  = dbg_wr & dbg_wdata[SRSO_DBG_FORCE];
    assign any_rst    = lv_reset | rst_src.pin_low | wd_expire | illegal_op
                      | rst_src.clkgen_req | force_rst;
    assign sys_reset  = (r_r.st == SRSO_HOLD);
    assign wdog_en_o  = r_r.wd_en;

    assign opts_rd = {r_r.wd_en, r_r.wd_long, r_r.stop_ok, 5'h00};
    assign clko_rd = {3'h0, r_r.ck_en, 1'b0, r_r.ck_div};

    // pin mux; the enable overrides the port direction
    assign pin_oe = r_r.ck_en | port_dir;
    assign pin_o  = r_r.ck_en ? r_r.ck_out : port_out;

    always_comb begin
        r_nxt = r_r;
        // bus address phase capture and read data
        r_nxt.ph_val = addr_ph;
        if (addr_ph) begin
            r_nxt.ph_wr   = hwrite;
            r_nxt.ph_addr = haddr[3:0];
            unique case (haddr[3:0])
                SRSO_OFF_STATUS: r_nxt.rdata = {24'h0, r_r.status};
                SRSO_OFF_OPTS:   r_nxt.rdata = {24'h0, opts_rd};
                SRSO_OFF_CLKO:   r_nxt.rdata = {24'h0, clko_rd};
                default:         r_nxt.rdata = 32'h0;
            endcase
        end
        // register writes; the forced-reset address is not writable from the bus
        if (wr_ph) begin
            if (r_r.ph_addr == SRSO_OFF_OPTS && !r_r.locked) begin
                r_nxt.wd_en   = hwdata[SRSO_OPT_WDEN];
                r_nxt.wd_long = hwdata[SRSO_OPT_WDLNG];
                r_nxt.stop_ok = hwdata[SRSO_OPT_STOP];
                r_nxt.locked  = 1'b1;
            end
            if (r_r.ph_addr == SRSO_OFF_CLKO) begin
                r_nxt.ck_en  = hwdata[SRSO_CLK_EN];
                r_nxt.ck_div = hwdata[SRSO_CLK_DLO +: SRSO_CLK_DW];
            end
        end
        // watchdog: restart on any status write, never counts when disabled
        if (wr_ph && r_r.ph_addr == SRSO_OFF_STATUS) begin
            r_nxt.wd_cnt = '0;
        end else if (r_r.wd_en && r_r.wd_cnt < wd_limit) begin
            r_nxt.wd_cnt = r_r.wd_cnt + SRSO_WDOG_W'(1);
        end
        // divided clock: toggles every ck_div cycles, period 2*ck_div
        if (!r_r.ck_en || r_r.ck_div == 3'h0) begin
            r_nxt.div_cnt = 3'h0;
            r_nxt.ck_out  = 1'b0;
        end else if (r_r.div_cnt >= r_r.ck_div - 3'h1) begin
            r_nxt.div_cnt = 3'h0;
            r_nxt.ck_out  = ~r_r.ck_out;
        end else begin
            r_nxt.div_cnt = r_r.div_cnt + 3'h1;
        end
        // reset sequencing
        unique case (r_r.st)
            SRSO_RUN: begin
                if (any_rst) begin
                    r_nxt.st       = SRSO_HOLD;
                    r_nxt.hold_cnt = 3'(SRSO_HOLD_CYC - 1);
                    r_nxt.status   = 8'h00;
                    if (lv_reset) begin
                        r_nxt.status[SRSO_ST_POR] = r_r.status[SRSO_ST_POR];
                        r_nxt.status[SRSO_ST_LVD] = 1'b1;
                    end else begin
                        r_nxt.status[SRSO_ST_PIN]  = rst_src.pin_low;
                        r_nxt.status[SRSO_ST_WDOG] = wd_expire;
                        r_nxt.status[SRSO_ST_ILLEGAL_OPCODE_FLAG] = illegal_op;
                        r_nxt.status[SRSO_ST_CLKG] = rst_src.clkgen_req;
                    end
                    r_nxt.wd_en   = SRSO_OPT_WDEN_RST;
                    r_nxt.wd_long = SRSO_OPT_WDLNG_RST;
                    r_nxt.stop_ok = SRSO_OPT_STOP_RST;
                    r_nxt.locked  = 1'b0;
                    r_nxt.ck_en   = 1'b0;
                    r_nxt.ck_div  = 3'h0;
                    r_nxt.wd_cnt  = '0;
                end
            end
            SRSO_HOLD: begin
                r_nxt.wd_cnt = '0;
                if (r_r.hold_cnt == 3'h0) begin
                    r_nxt.st = SRSO_RUN;
                end else begin
                    r_nxt.hold_cnt = r_r.hold_cnt - 3'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            r_r          <= '0;
            r_r.st       <= SRSO_RUN;
            r_r.status   <= SRSO_ST_RST;
            r_r.wd_en    <= SRSO_OPT_WDEN_RST;
            r_r.wd_long  <= SRSO_OPT_WDLNG_RST;
            r_r.stop_ok  <= SRSO_OPT_STOP_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ------------------------------------------------------------ checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    logic run_s;
    assign run_s = (r_r.st == SRSO_RUN);

    property p_status_resv;
        r_r.status[3] == 1'b0 && r_r.status[0] == 1'b0;
    endproperty
    a_status_resv: assert property (p_status_resv)
        else $error("reserved status bits not zero");

    property p_force_clear;
        run_s && force_rst && !lv_reset && !rst_src.pin_low && !wd_expire
            && !illegal_op && !rst_src.clkgen_req |=> r_r.status == 8'h00;
    endproperty
    a_force_clear: assert property (p_force_clear)
        else $error("forced reset left a status flag set");

    property p_status_wr;
        run_s && !any_rst && wr_ph && r_r.ph_addr == SRSO_OFF_STATUS
            |=> $stable(r_r.status) && r_r.wd_cnt == '0;
    endproperty
    a_status_wr: assert property (p_status_wr)
        else $error("status write changed flags or kept watchdog count");

    property p_por_lvd;
        r_r.status[SRSO_ST_POR] |-> r_r.status[SRSO_ST_LVD];
    endproperty
    a_por_lvd: assert property (p_por_lvd)
        else $error("power-on flag without low-voltage flag");

    property p_lvr;
        run_s && lv_reset |=> r_r.status[SRSO_ST_POR] == $past(r_r.status[SRSO_ST_POR])
            && r_r.status[6:2] == 5'h00 && r_r.status[SRSO_ST_LVD] ##1 sys_reset;
    endproperty
    a_lvr: assert property (p_lvr)
        else $error("low-voltage reset flags wrong");

    property p_other;
        run_s && any_rst && !lv_reset |=> !r_r.status[SRSO_ST_POR]
            && !r_r.status[SRSO_ST_LVD]
            && r_r.status[SRSO_ST_PIN] == $past(rst_src.pin_low)
            && r_r.status[SRSO_ST_ILLEGAL_OPCODE_FLAG] == $past(illegal_op);
    endproperty
    a_other: assert property (p_other)
        else $error("cause flags do not follow sources");

    property p_wd_off;
        !r_r.wd_en |-> !wd_expire ##1 !r_r.status[SRSO_ST_WDOG] || !$changed(r_r.status);
    endproperty
    a_wd_off: assert property (p_wd_off)
        else $error("watchdog reset while disabled");

    property p_lv_gate;
        $past(run_s) && $rose(r_r.status[SRSO_ST_LVD]) |-> $past(lv_reset);
    endproperty
    a_lv_gate: assert property (p_lv_gate)
        else $error("low-voltage flag without gated trip");

    property p_dbg_read;
        addr_ph && !hwrite && haddr[3:0] == SRSO_OFF_DBGRST |=> hrdata == 32'h0;
    endproperty
    a_dbg_read: assert property (p_dbg_read)
        else $error("forced-reset register read nonzero");

    property p_once;
        run_s && !any_rst && r_r.locked |=> $stable(opts_rd);
    endproperty
    a_once: assert property (p_once)
        else $error("locked options changed");

    property p_wd_bound;
        r_r.wd_cnt <= wd_limit || $changed(r_r.wd_long);
    endproperty
    a_wd_bound: assert property (p_wd_bound)
        else $error("watchdog count beyond period");

    property p_div;
        r_r.ck_en && r_r.ck_div != 3'h0 && $stable(r_r.ck_div) && $changed(r_r.ck_out)
            |-> $past(r_r.div_cnt) == r_r.ck_div - 3'h1;
    endproperty
    a_div: assert property (p_div)
        else $error("clock output toggled at wrong count");

    property p_low;
        r_r.ck_en && r_r.ck_div == 3'h0 |=> !pin_o || !r_r.ck_en || r_r.ck_div != 3'h0;
    endproperty
    a_low: assert property (p_low)
        else $error("clock output not low with zero select");

    property p_oe;
        r_r.ck_en |-> pin_oe && pin_o == r_r.ck_out;
    endproperty
    a_oe: assert property (p_oe)
        else $error("clock output enable did not take the pin");

    c_wd_reset: cover property (run_s && wd_expire ##1 r_r.status[SRSO_ST_WDOG]);
    c_force:    cover property (run_s && force_rst ##1 sys_reset);
    c_lock:     cover property (r_r.locked ##1 wr_ph && r_r.ph_addr == SRSO_OFF_OPTS);
    c_clk_div3: cover property (r_r.ck_en && r_r.ck_div == 3'h3 && $rose(r_r.ck_out));

endmodule
`default_nettype wire

// ==== testbench/srso_host_mdl.sv ====
// reset source and background debug host model for the status block
`timescale 1ns/1ps
`default_nettype none
module srso_host_mdl
    import srso_pkg::*;
(
    input  wire logic       clk_sys,
    output var  srso_src_s  rst_src,
    output logic            dbg_wr,
    output logic [7:0]      dbg_wdata
);
    initial begin
        rst_src   = '0;
        dbg_wr    = 1'b0;
        dbg_wdata = 8'h00;
    end
    task automatic set_src(input srso_src_s v);
        @(posedge clk_sys);
        rst_src <= v;
    endtask
    // one cycle is enough; longer would only stretch the hold
    task automatic pulse(input srso_src_s v);
        set_src(v);
        set_src('0);
    endtask
    // released data flips so a stale byte never looks valid
    task automatic dbg_write(input logic [7:0] d);
        @(posedge clk_sys);
        dbg_wr    <= 1'b1;
        dbg_wdata <= d;
        @(posedge clk_sys);
        dbg_wr    <= 1'b0;
        dbg_wdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ==== testbench/system_reset_status_options_test.sv ====
// self-checking bench of the reset status, options and clock output block
`timescale 1ns/1ps
`default_nettype none
module system_reset_status_options_test;
    import srso_pkg::*;
    localparam int WS = 32;
    localparam int WL = 1024;
    logic        clk_sys     = 1'b0;
    logic        arst_n      = 1'b0;
    logic        hsel        = 1'b0;
    logic        hwrite      = 1'b0;
    logic [1:0]  htrans      = 2'b00;
    logic [2:0]  hsize       = 3'b000;
    logic [31:0] haddr       = '0;
    logic [31:0] hwdata      = '0;
    logic        bdm_allow   = 1'b0;
    logic        lv_reset_en = 1'b0;
    logic        lv_stop_en  = 1'b0;
    logic        port_out    = 1'b1;
    logic        port_dir    = 1'b0;
    logic        hreadyout, hresp, sys_reset, stop_enter, wdog_en_o, pin_o, pin_oe, dbg_wr;
    logic [31:0] hrdata;
    logic [7:0]  dbg_wdata;
    logic [7:0]  rd;
    srso_src_s   rst_src;
    int          n_fail      = 0;
    int          checks_done = 0;
    int          cyc         = 0;
    int          n, t0;

    always #25 clk_sys = ~clk_sys;

    srso_top #(.WDOG_SHORT(WS), .WDOG_LONG(WL)) dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rst_src(rst_src),
        .bdm_allow(bdm_allow), .lv_reset_en(lv_reset_en), .lv_stop_en(lv_stop_en),
        .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata), .sys_reset(sys_reset),
        .stop_enter(stop_enter), .wdog_en_o(wdog_en_o), .port_out(port_out),
        .port_dir(port_dir), .pin_o(pin_o), .pin_oe(pin_oe));
    srso_host_mdl host (.clk_sys(clk_sys), .rst_src(rst_src), .dbg_wr(dbg_wr),
        .dbg_wdata(dbg_wdata));

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chki(input string nm, input int e, input int g);
        checks_done++;
        if (g != e) begin
            n_fail++;
            $display("mismatch %s exp %0d got %0d", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {28'h0, a};
        hwrite <= w;
        hsize  <= 3'b010;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
    endtask
    task automatic reg_is(input string nm, input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk8(nm, e, rd);
    endtask
    // n == lim means no internal reset came
    task automatic wait_rst(input int lim, output int c);
        c = 0;
        while (sys_reset !== 1'b1 && c < lim) begin
            @(negedge clk_sys);
            c++;
        end
        while (sys_reset === 1'b1) @(negedge clk_sys);
    endtask

    task automatic t_por;
        reg_is("status", SRSO_OFF_STATUS, 8'h82);
        reg_is("options", SRSO_OFF_OPTS, 8'hc0);
        reg_is("clkout", SRSO_OFF_CLKO, 8'h00);
        reg_is("dbgrst", SRSO_OFF_DBGRST, 8'h00);
        chk8("wden", 8'h01, {7'h0, wdog_en_o});
        chk8("hresp", 8'h00, {7'h0, hresp});
        bus(1'b1, SRSO_OFF_STATUS, 8'hff);
        reg_is("status ro", SRSO_OFF_STATUS, 8'h82);
        bus(1'b1, SRSO_OFF_DBGRST, 8'h01);
        wait_rst(20, n);
        chki("bus force", 20, n);
    endtask
    task automatic t_lv;
        @(posedge clk_sys);
        lv_reset_en <= 1'b1;
        host.pulse(6'h01);
        wait_rst(20, n);
        chki("lv one enable", 20, n);
        @(posedge clk_sys);
        lv_stop_en <= 1'b1;
        host.pulse(6'h01);
        wait_rst(20, n);
        chki("lv reset", 1, int'(n < 20));
        reg_is("status lv", SRSO_OFF_STATUS, 8'h82);
    endtask
    task automatic t_src;
        logic [5:0] sv [7] = '{6'h20, 6'h10, 6'h08, 6'h02, 6'h04, 6'h30, 6'h01};
        logic [7:0] ev [7] = '{8'h40, 8'h04, 8'h10, 8'h10, 8'h10, 8'h44, 8'h02};
        for (int i = 0; i < 7; i++) begin
            host.pulse(sv[i]);
            wait_rst(20, n);
            reg_is("status src", SRSO_OFF_STATUS, ev[i]);
        end
        reg_is("options back", SRSO_OFF_OPTS, 8'hc0);
        @(posedge clk_sys);
        bdm_allow <= 1'b1;
        host.pulse(6'h02);
        wait_rst(20, n);
        chki("background_instruction allowed", 20, n);
    endtask
    task automatic t_once;
        bus(1'b1, SRSO_OFF_OPTS, 8'h6c);
        reg_is("options", SRSO_OFF_OPTS, 8'h60);
        bus(1'b1, SRSO_OFF_OPTS, 8'ha0);
        reg_is("options locked", SRSO_OFF_OPTS, 8'h60);
        chk8("wden", 8'h00, {7'h0, wdog_en_o});
        host.set_src(6'h04);
        @(negedge clk_sys);
        chk8("stop", 8'h01, {7'h0, stop_enter});
        host.set_src(6'h00);
        wait_rst(WL + 100, n);
        chki("no wdog", WL + 100, n);
    endtask
    task automatic t_dbg;
        host.dbg_write(8'h00);
        wait_rst(20, n);
        chki("dbg zero", 20, n);
        host.dbg_write(8'h01);
        wait_rst(20, n);
        chki("dbg force", 1, int'(n < 20));
        reg_is("status dbg", SRSO_OFF_STATUS, 8'h00);
        reg_is("options free", SRSO_OFF_OPTS, 8'hc0);
    endtask
    task automatic t_wdog;
        bus(1'b1, SRSO_OFF_OPTS, 8'h80);
        // the count runs since the last reset: restart before timing it
        bus(1'b1, SRSO_OFF_STATUS, 8'h55);
        repeat (4) begin
            wait_rst(WS - 8, n);
            chki("wdog restart", WS - 8, n);
            bus(1'b1, SRSO_OFF_STATUS, 8'h55);
        end
        reg_is("status kept", SRSO_OFF_STATUS, 8'h00);
        wait_rst(WS + 20, n);
        chki("short period", 1, int'(n >= WS - 8 && n <= WS + 2));
        reg_is("status wdog", SRSO_OFF_STATUS, 8'h20);
        wait_rst(WL + 20, n);
        chki("long period", 1, int'(n >= WL - 8 && n <= WL + 2));
    endtask
    task automatic t_clk;
        int dv [3] = '{1, 3, 7};
        foreach (dv[i]) begin
            bus(1'b1, SRSO_OFF_CLKO, 8'h10 | 8'(dv[i]));
            @(posedge pin_o);
            t0 = cyc;
            @(posedge pin_o);
            chki("clk period", 2 * dv[i], cyc - t0);
        end
        chk8("pin oe", 8'h01, {7'h0, pin_oe});
        bus(1'b1, SRSO_OFF_CLKO, 8'h10);
        // the registered clock output lags the new select by one cycle
        @(posedge clk_sys);
        repeat (8) begin
            @(negedge clk_sys);
            chk8("pin low", 8'h02, {6'h0, pin_oe, pin_o});
        end
        bus(1'b1, SRSO_OFF_CLKO, 8'h03);
        @(negedge clk_sys);
        chk8("pin port", 8'h01, {6'h0, pin_oe, pin_o});
        @(posedge clk_sys);
        port_out <= 1'b0;
        port_dir <= 1'b1;
        @(negedge clk_sys);
        chk8("pin port drive", 8'h02, {6'h0, pin_oe, pin_o});
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ceiling well above the roughly 2600 cycles the tests need
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 12000) begin
            n_fail++;
            give_verdict;
        end
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_por;
        $display("test por done");
        t_lv;
        $display("test lv done");
        t_src;
        $display("test src done");
        t_once;
        $display("test once done");
        t_dbg;
        $display("test dbg done");
        t_wdog;
        $display("test wdog done");
        t_clk;
        $display("test clk done");
        give_verdict;
    end
endmodule
`default_nettype wire
